// File: hdl/pin_control_defines.vh
// constants for the attach and low-power indicator pin control block
// assumes a plain register port and one 200 MHz clock
`ifndef PIN_CONTROL_DEFINES_VH
`define PIN_CONTROL_DEFINES_VH
`define HWCFG_OFFSET      12'h0010
`define BIT_PROTECT       12
`define BIT_EMUL          13
`define BIT_RESERVED      11
`define BIT_BUF_TYPE      10
`define BIT_ATTACH_EN     9
`define BIT_ATTACH_POL    8
`define SEL_HI            7
`define SEL_LO            6
`define BIT_SUSP_POL      5
`define PROT_MASK         32'h0000_37E0
`define WRITE_MASK        32'h0000_37E0
`define FIELD_RESET       32'h0000_0000
`endif

// File: hdl/sleep_state_decode.v
// low-power indicator decode from sleep state and selection field
// assumes sleep state inputs are synchronous one-hot or zero levels
`timescale 1ns/10ps
module sleep_state_decode
(
   input  wire [1:0] select_in,
   input  wire       state_zero_in,
   input  wire       state_one_in,
   input  wire       state_two_in,
   input  wire       state_three_in,
   input  wire       detached_in,
   output wire       assert_out
);
   // each code widens the set of states; no emulation or memory gating here
   assign assert_out = state_two_in
      | ((select_in != 2'h0) & (state_one_in | detached_in))
      | (select_in[1] & state_zero_in)
      | ((select_in == 2'h3) & state_three_in);
endmodule // sleep_state_decode

// File: hdl/pin_control.v
// hardware configuration register bank driving attach and low-power pins
// assumes synchronous inputs, one clock, and a board pull-up for open drain
`timescale 1ns/10ps
`include "pin_control_defines.vh"
module pin_control
(
   // clock and power-on reset
   input  wire        clock_in,
   input  wire        resetn_in,
   // soft resets and the configuration image they reload
   input  wire        usb_reset_in,
   input  wire        lite_soft_reset_in,
   input  wire        image_valid_in,
   input  wire [31:0] image_in,
   // device status levels
   input  wire        hsic_mode_in,
   input  wire        attaching_in,
   input  wire        reattaching_in,
   input  wire        cable_detached_in,
   input  wire        sleep_state_zero_in,
   input  wire        sleep_state_one_in,
   input  wire        sleep_state_two_in,
   input  wire        sleep_state_three_in,
   // register port
   input  wire [11:0] addr_in,
   input  wire [31:0] wdata_in,
   input  wire        write_in,
   input  wire        read_in,
   output reg  [31:0] rdata_out,
   // pins
   output wire        attach_pin_out,
   output wire        attach_pin_oe_out,
   output wire        low_power_pin_out,
   output wire        descriptor_emulation_enable_out
);
   // ***************************************************************
   // field masks
   // ***************************************************************
   // bits 13, 12 and 10:5 are the only ones this bank stores
   localparam [31:0] STORE_MASK  = `WRITE_MASK;
   // protected fields are the ones a soft reset may reload
   localparam [31:0] RELOAD_MASK = `PROT_MASK;

   // ***************************************************************
   // register storage
   // ***************************************************************
   reg  [31:0] cfg_q;
   reg  [31:0] cfg_d;
   reg  [31:0] rdata_d;
   reg         hit;
   wire        soft_reset;
   wire [31:0] reload_word;
   wire [31:0] write_word;
   wire        sleep_assert;
   reg         low_power_level;
   wire        attach_active;
   reg         attach_level;

   // ***************************************************************
   // field views of the stored word
   // ***************************************************************
   wire        buf_push_pull;
   wire        attach_enable;
   wire        attach_polarity;
   wire [1:0]  sleep_select;
   wire        sleep_polarity;
   wire        protect;
   wire        emulation;

   // one name per field so the pin logic reads like the register map
   assign buf_push_pull   = cfg_q[`BIT_BUF_TYPE];
   assign attach_enable   = cfg_q[`BIT_ATTACH_EN];
   assign attach_polarity = cfg_q[`BIT_ATTACH_POL];
   assign sleep_select    = cfg_q[`SEL_HI:`SEL_LO];
   assign sleep_polarity  = cfg_q[`BIT_SUSP_POL];
   assign protect         = cfg_q[`BIT_PROTECT];
   assign emulation       = cfg_q[`BIT_EMUL];

   // ***************************************************************
   // address decode
   // ***************************************************************
   // one register lives here; every other offset reads zero
   always @*
   begin
      if (addr_in == `HWCFG_OFFSET)
      begin
         hit = 1'b1;
      end
      else
      begin
         hit = 1'b0;
      end
   end

   // ***************************************************************
   // write and reload words
   // ***************************************************************
   assign soft_reset = usb_reset_in | lite_soft_reset_in;

   // per bit: only mapped bits pass; reserved bit 11 is never stored
   genvar bit_idx;
   generate
      for (bit_idx = 0; bit_idx < 32; bit_idx = bit_idx + 1)
      begin : g_mask
         assign write_word[bit_idx]  = STORE_MASK[bit_idx] & wdata_in[bit_idx];
         // no image means zeros
         assign reload_word[bit_idx] = RELOAD_MASK[bit_idx]
                                       & image_valid_in & image_in[bit_idx];
      end
   endgenerate

   // soft reset beats a same-cycle write; protection freezes every field against soft reset, not against writes
   always @*
   begin
      cfg_d = cfg_q;
      if (soft_reset)
      begin
         if (!protect)
         begin
            cfg_d = reload_word;
         end
      end
      else if (write_in && hit)
      begin
         cfg_d = write_word;
      end
   end

   // power-on reset clears everything, protection or not
   always @(posedge clock_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         cfg_q <= `FIELD_RESET;
      end
      else
      begin
         cfg_q <= cfg_d;
      end
   end

   // ***************************************************************
   // read path
   // ***************************************************************
   // zero unless the strobe hits the register
   always @*
   begin
      if (read_in && hit)
      begin
         rdata_d = cfg_q;
      end
      else
      begin
         rdata_d = 32'h0000_0000;
      end
   end

   // read data stand for exactly the cycle after the strobe
   always @(posedge clock_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         rdata_out <= 32'h0000_0000;
      end
      else
      begin
         rdata_out <= rdata_d;
      end
   end

   // ***************************************************************
   // low-power indicator pin
   // ***************************************************************
   // which sleep states assert the pin; emulation plays no part
   sleep_state_decode u_decode
   (
      .select_in      (sleep_select),
      .state_zero_in  (sleep_state_zero_in),
      .state_one_in   (sleep_state_one_in),
      .state_two_in   (sleep_state_two_in),
      .state_three_in (sleep_state_three_in),
      .detached_in    (cable_detached_in),
      .assert_out     (sleep_assert)
   );

   // polarity turns the logical assert into a pin level
   always @*
   begin
      if (sleep_polarity)
      begin
         low_power_level = sleep_assert;
      end
      else
      begin
         low_power_level = ~sleep_assert;
      end
   end
   assign low_power_pin_out = low_power_level;

   // ***************************************************************
   // attach request pin
   // ***************************************************************
   // attach function only exists in hsic mode
   assign attach_active = hsic_mode_in & attach_enable
                          & (attaching_in | reattaching_in);

   // outside hsic polarity falls back to active low, so the idle level is high
   always @*
   begin
      if (hsic_mode_in && attach_polarity)
      begin
         attach_level = attach_active;
      end
      else
      begin
         attach_level = ~attach_active;
      end
   end

   // open drain only pulls low; the board pull-up makes the high level
   assign attach_pin_out    = attach_level;
   assign attach_pin_oe_out = buf_push_pull | ~attach_level;

   // stored only; nothing in this block acts on it
   assign descriptor_emulation_enable_out = emulation;
endmodule // pin_control

// File: tb/attach_board.sv
// board side of the attach pin: a pull-up on the wire
// assumes oe high while the device drives the pin
`timescale 1ns/10ps
module attach_board
(
   input  wire logic pin_in,
   input  wire logic oe_in,
   output wire logic level_out
);
   // released open drain floats up to the pull-up
   assign level_out = oe_in ? pin_in : 1'b1;
endmodule // attach_board

// File: tb/pin_control_monitor.sv
// assertions on the register and pins of pin_control
// assumes it is bound onto pin_control
`timescale 1ns/10ps
`include "pin_control_defines.vh"
module pin_control_monitor
(
   input wire logic        clock_in,
   input wire logic        resetn_in,
   input wire logic        usb_reset_in,
   input wire logic        lite_soft_reset_in,
   input wire logic        image_valid_in,
   input wire logic [31:0] image_in,
   input wire logic        hsic_mode_in,
   input wire logic        attaching_in,
   input wire logic        reattaching_in,
   input wire logic        cable_detached_in,
   input wire logic        sleep_state_zero_in,
   input wire logic        sleep_state_one_in,
   input wire logic        sleep_state_two_in,
   input wire logic        sleep_state_three_in,
   input wire logic [11:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic        write_in,
   input wire logic        read_in,
   input wire logic [31:0] rdata_out,
   input wire logic        attach_pin_out,
   input wire logic        attach_pin_oe_out,
   input wire logic        low_power_pin_out
);
   // shadow copy; soft reset beats a write
   logic [31:0] s_q;
   wire sr = usb_reset_in | lite_soft_reset_in;
   always_ff @(posedge clock_in or negedge resetn_in)
      if (!resetn_in) s_q <= 32'h0000_0000;
      else if (sr) s_q <= s_q[12] ? s_q : image_valid_in ? image_in & `WRITE_MASK : 32'h0000_0000;
      else if (write_in && addr_in == `HWCFG_OFFSET) s_q <= wdata_in & `WRITE_MASK;
   wire act = hsic_mode_in & s_q[9] & (attaching_in | reattaching_in);
   wire dec = sleep_state_two_in | (|s_q[7:6]) & (sleep_state_one_in | cable_detached_in)
      | s_q[7] & sleep_state_zero_in | (&s_q[7:6]) & sleep_state_three_in;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   open_drain_a: assert property (!s_q[10] |-> !attach_pin_oe_out || !attach_pin_out)
      else $error("open drain high");
   push_pull_a: assert property (s_q[10] |-> attach_pin_oe_out) else $error("pp oe");
   attach_high_a: assert property (act && s_q[8] && s_q[10] |-> attach_pin_out)
      else $error("attach high");
   attach_low_a: assert property (act && !s_q[8] |-> attach_pin_oe_out && !attach_pin_out)
      else $error("attach low");
   // outside hsic the pin idles at the active-low deasserted level
   no_hsic_a: assert property (!hsic_mode_in |-> attach_pin_out)
      else $error("attach pin not idle outside hsic");
   low_power_a: assert property (low_power_pin_out == (s_q[5] ? dec : !dec))
      else $error("low power pin");
   read_value_a: assert property (
      read_in && addr_in == `HWCFG_OFFSET |=> rdata_out == $past(s_q))
      else $error("read data");
   reserved_zero_a: assert property (rdata_out[11] == 1'b0) else $error("bit 11");
   cover property (act);
   cover property (sr && s_q[12]);
   cover property (read_in);
endmodule // pin_control_monitor
bind pin_control pin_control_monitor u_mon (.*);

// File: tb/test_attach_and_suspend_pin_control.sv
// bench for pin_control: table of sleep cases, then attach and reset cases
// assumes a 200 MHz clock and a board pull-up on the attach pin
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
   $display("wrong value %s exp %h got %h", n, e, a); end end
module test_attach_and_suspend_pin_control;
   logic clock_in = 0, resetn_in = 0, usb_reset_in = 0, lite_soft_reset_in = 0;
   logic image_valid_in = 0, hsic_mode_in = 0, attaching_in = 0, reattaching_in = 0;
   logic cable_detached_in = 0, sleep_state_zero_in = 0, sleep_state_one_in = 0;
   logic sleep_state_two_in = 0, sleep_state_three_in = 0, write_in = 0, read_in = 0;
   logic [11:0] addr_in = 12'h000;
   logic [31:0] image_in = 32'h0000_0000, wdata_in = 32'h0000_0000, d;
   wire  [31:0] rdata_out;
   wire attach_pin_out, attach_pin_oe_out, low_power_pin_out, descriptor_emulation_enable_out, lvl;
   int errors = 0, checks = 0;
   // rows: select, polarity, three zero one two detach, expected pin
   logic [8:0] rows [8] = '{9'h004, 9'h048, 9'h0C3, 9'h091, 9'h151, 9'h160, 9'h1E1, 9'h188};
   always #2.5 clock_in = ~clock_in;
   pin_control u_dut (.*);
   attach_board u_board (.pin_in(attach_pin_out), .oe_in(attach_pin_oe_out), .level_out(lvl));
   task wr(input [31:0] v);
      @(posedge clock_in) {write_in, addr_in, wdata_in} <= {1'b1, 12'h010, v};
      @(posedge clock_in) write_in <= 0;
      #1;
   endtask
   task rd(input [11:0] a);
      @(posedge clock_in) {read_in, addr_in} <= {1'b1, a};
      @(posedge clock_in) read_in <= 0;
      #1 d = rdata_out;
   endtask
   // one cycle of a soft reset, usb or lite
   task pulse(input lite);
      @(posedge clock_in) {lite_soft_reset_in, usb_reset_in} <= {lite, !lite};
      @(posedge clock_in) {lite_soft_reset_in, usb_reset_in} <= 2'b00;
   endtask
   task stop_test;
      if (errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // watchdog: the run needs well under 300 cycles
   initial begin #20000; errors++; stop_test; end
   initial
   begin
      repeat (20) @(posedge clock_in);
      resetn_in <= 1;
      foreach (rows[i])
      begin
         wr({18'h0, 1'(i % 2), 5'h0, rows[i][8:6], 5'h0}); // emulation bit toggles
         {sleep_state_three_in, sleep_state_zero_in, sleep_state_one_in} <= rows[i][5:3];
         {sleep_state_two_in, cable_detached_in} <= rows[i][2:1];
         @(posedge clock_in) #1 `CHK("low power", rows[i][0], low_power_pin_out)
         `CHK("emulation", 1'(i % 2), descriptor_emulation_enable_out)
      end
      hsic_mode_in <= 1;
      attaching_in <= 1;
      wr(32'h0000_0700);
      `CHK("attach pp", 2'b11, {attach_pin_out, attach_pin_oe_out})
      {attaching_in, reattaching_in} <= 2'b01;
      wr(32'h0000_0200);
      `CHK("reattach", 1'b0, lvl)
      reattaching_in <= 0;
      @(posedge clock_in) #1 `CHK("released", 1'b1, lvl)
      {hsic_mode_in, attaching_in} <= 2'b01;
      wr(32'h0000_0700);
      `CHK("no hsic", 2'b11, {attach_pin_out, attach_pin_oe_out})
      wr(32'hFFFF_FFFF);
      rd(12'h010); `CHK("reg", 32'h0000_37E0, d)
      rd(12'h014); `CHK("unmapped", 32'h0000_0000, d)
      pulse(0); rd(12'h010); `CHK("protected", 32'h0000_37E0, d)
      // power-on reset in mid-run clears even protected fields
      @(posedge clock_in) resetn_in <= 0;
      repeat (2) @(posedge clock_in);
      resetn_in <= 1;
      rd(12'h010); `CHK("power-on", 32'h0000_0000, d)
      {image_valid_in, image_in} <= {1'b1, 32'hFFFF_C940};
      wr(32'h0000_00E0); pulse(0); rd(12'h010); `CHK("image", 32'h0000_0140, d)
      image_valid_in <= 0;
      pulse(1); rd(12'h010); `CHK("no image", 32'h0000_0000, d)
      // a write in the same cycle as a soft reset is lost
      @(posedge clock_in) {write_in, addr_in, wdata_in, usb_reset_in}
         <= {1'b1, 12'h010, 32'h0000_00E0, 1'b1};
      @(posedge clock_in) {write_in, usb_reset_in} <= 2'b00;
      rd(12'h010); `CHK("reset beats write", 32'h0000_0000, d)
      stop_test;
   end
endmodule // test_attach_and_suspend_pin_control
